/* File: src/twass_map.vh */
// Purpose: Shared constants of the two-wire sample sequencer
// Assumes: Included by every twass design file
// Notes: Definitions only
`ifndef TWASS_MAP_VH
`define TWASS_MAP_VH

// Converter resolution and step count
`define TWASS_RES_BITS 10
`define TWASS_SAR_STEPS 4'hA
// Bus byte framing
`define TWASS_LAST_BIT 4'h7
// Setup byte fields
`define TWASS_REG_BIT 7
`define TWASS_SU_REFSEL_HI 6
`define TWASS_SU_REFSEL_LO 4
`define TWASS_SU_CLK_BIT 3
`define TWASS_SU_POL_BIT 2
`define TWASS_SU_RSTN_BIT 1
// Configuration byte fields
`define TWASS_CF_SCAN_HI 6
`define TWASS_CF_SCAN_LO 5
`define TWASS_CF_CS_HI 4
`define TWASS_CF_CS_LO 1
`define TWASS_CF_SGL_BIT 0
// Reset values
`define TWASS_RST_REFSEL 3'h0
`define TWASS_RST_CLK 1'h0
`define TWASS_RST_POL 1'h0
`define TWASS_RST_SCAN 2'h0
`define TWASS_RST_CS 4'h0
`define TWASS_RST_SGL 1'h1
// Internal conversion clock divider default
`define TWASS_CONV_DIV 8'h04

`endif

/* File: src/twass_sar.v */
// Purpose: Successive-approximation register, one result bit per step
// Assumes: step_i pulses once per conversion clock, comp_i valid on mclk_i
// Notes: Trial code goes straight to the capacitive DAC
`timescale 1ns/1ps
`include "twass_map.vh"

module twass_sar (
    input wire mclk_i,
    input wire reset_i,
    input wire start_i,
    input wire step_i,
    input wire comp_i,
    output wire [9:0] dac_code_o,
    output reg [9:0] code_o,
    output reg done_o,
    output wire busy_o
);

    reg [9:0] trial_r;   // Current trial code
    reg [3:0] left_r;    // Steps still to take
    reg [3:0] pos_r;     // Bit under test

    assign dac_code_o = trial_r;
    assign busy_o = (left_r != 4'h0);

    // One decision per step, exactly ten steps
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            trial_r <= 10'h000;
            left_r <= 4'h0;
            pos_r <= 4'h0;
            code_o <= 10'h000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                // Midscale first trial
                trial_r <= 10'h200;
                pos_r <= 4'h9;
                left_r <= `TWASS_SAR_STEPS;
            end else if (step_i && busy_o) begin
                // Comparator low means input below trial: drop the bit
                if (pos_r == 4'h0) begin
                    code_o <= comp_i ? trial_r : (trial_r & 10'h3FE);
                    done_o <= 1'b1;
                    trial_r <= comp_i ? trial_r : (trial_r & 10'h3FE);
                end else begin
                    trial_r <= (comp_i ? trial_r : (trial_r & ~(10'h001 << pos_r)))
                        | (10'h001 << (pos_r - 4'h1));
                    pos_r <= pos_r - 4'h1;
                end
                left_r <= left_r - 4'h1;
            end
        end
    end

endmodule // twass_sar

/* File: src/twass_core.v */
// Purpose: Digital control of a 10-bit two-wire sampling converter
// Assumes: Open-drain SCL/SDA sampled by mclk_i, much faster than SCL
// Notes: Address match, conversion timing, coding and bit-level bus
`timescale 1ns/1ps
`include "twass_map.vh"

module twass_core #(
    parameter [6:0] SLAVE_ADDR = 7'h2A,      // Arbitrary default address
    parameter [7:0] CONV_DIV = `TWASS_CONV_DIV // mclk cycles per internal conversion clock
) (
    input wire mclk_i,
    input wire reset_i,
    input wire scl_in_i,
    output wire scl_out_o,
    output wire scl_oe_o,
    input wire sda_in_i,
    output wire sda_out_o,
    output wire sda_oe_o,
    input wire comp_i,
    output wire [9:0] dac_code_o,
    output reg track_o,
    output reg [3:0] channel_select_o,
    output reg single_diff_select_o,
    output reg polarity_select_o,
    output reg external_clock_o,
    output reg [2:0] reference_select_o,
    output reg [1:0] scan_select_o,
    output reg [9:0] result_o,
    output reg result_valid_o,
    output wire busy_o
);

    // Bus sequencer states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_AACK = 3'h2;
    localparam [2:0] ST_WRITE = 3'h3;
    localparam [2:0] ST_WACK = 3'h4;
    localparam [2:0] ST_CONV = 3'h5;
    localparam [2:0] ST_READ = 3'h6;
    localparam [2:0] ST_RACK = 3'h7;

    reg scl_m_r, scl_s_r, scl_d_r; // SCL synchroniser and delay
    reg sda_m_r, sda_s_r, sda_d_r; // SDA synchroniser and delay
    reg [2:0] state_r;             // Sequencer state
    reg [3:0] bit_r;               // Bit index in byte
    reg [7:0] shift_r;             // Receive or transmit shifter
    reg rw_r;                      // Direction of this transfer
    reg lo_byte_r;                 // Byte now being read is the low half
    reg sda_low_r;                 // Pulling SDA low
    reg scl_low_r;                 // Stretching SCL
    reg [3:0] rise_cnt_r;          // Rises into first result byte
    reg ext_conv_r;                // External conversion in progress
    reg [7:0] div_r;               // Internal conversion clock divider
    reg sar_start_r;               // Launch pulse for the SAR

    wire scl_rise = scl_s_r & ~scl_d_r;
    wire scl_fall = ~scl_s_r & scl_d_r;
    // SDA moving while SCL high is a bus condition, not data
    wire bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    wire bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    wire addr_hit = (shift_r[7:1] == SLAVE_ADDR); // Address sits above the R/W bit
    wire int_tick = (div_r == 8'h00);
    wire [9:0] sar_code;
    wire sar_done;
    wire sar_step;

    // Coding the raw code needs to pick
    wire bip_eff = ~single_diff_select_o & polarity_select_o;

    // Only ever pull low; the high level comes from the pull-ups
    assign scl_out_o = 1'b0;
    assign sda_out_o = 1'b0;
    assign scl_oe_o = scl_low_r;
    assign sda_oe_o = sda_low_r;

    // Conversion clock: own divider internally, SCL rises externally
    assign sar_step = external_clock_o ? (scl_rise & ext_conv_r) : int_tick;

    // Raw SAR to output coding
    function [9:0] twass_code;
        input [9:0] raw;
        input bip;
        begin
            // Bipolar offset binary becomes two's complement
            twass_code = bip ? {~raw[9], raw[8:0]} : raw;
        end
    endfunction

    twass_sar i_twass_sar (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .start_i(sar_start_r),
        .step_i(sar_step),
        .comp_i(comp_i),
        .dac_code_o(dac_code_o),
        .code_o(sar_code),
        .done_o(sar_done),
        .busy_o(busy_o)
    );

    // Two flops on each pin before anything reads them; ample for 1.7 MHz SCL
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in_i;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_in_i;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    // Internal conversion clock; free-running divider
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            div_r <= 8'h00;
        end else if (int_tick) begin
            div_r <= CONV_DIV - 8'h01;
        end else begin
            div_r <= div_r - 8'h01;
        end
    end

    // Result capture with coding applied
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            result_o <= 10'h000;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= sar_done;
            if (sar_done) begin
                // Unipolar: negative input fails every trial, so code is 0
                // Single-ended forces binary whatever the polarity bit
                result_o <= twass_code(sar_code, bip_eff);
            end
        end
    end

    // Bus sequencer; SCL comes from the master, held low here only during an internal-clock conversion
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            lo_byte_r <= 1'b0;
            sda_low_r <= 1'b0;
            scl_low_r <= 1'b0;
            rise_cnt_r <= 4'h0;
            ext_conv_r <= 1'b0;
            sar_start_r <= 1'b0;
            track_o <= 1'b0;
            reference_select_o <= `TWASS_RST_REFSEL;
            external_clock_o <= `TWASS_RST_CLK;
            polarity_select_o <= `TWASS_RST_POL;
            scan_select_o <= `TWASS_RST_SCAN;
            channel_select_o <= `TWASS_RST_CS;
            single_diff_select_o <= `TWASS_RST_SGL;
        end else begin
            sar_start_r <= 1'b0;
            if (sar_done) begin
                ext_conv_r <= 1'b0;
            end
            if (bus_stop) begin
                // Release both lines when the bus goes idle
                state_r <= ST_IDLE;
                sda_low_r <= 1'b0;
                scl_low_r <= 1'b0;
            end else if (bus_start) begin
                state_r <= ST_ADDR;
                bit_r <= 4'h0;
                sda_low_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_ADDR: begin
                        // One bit per SCL cycle, taken on the rise
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s_r};
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == `TWASS_LAST_BIT) begin
                                // Address LSB picks direction
                                rw_r <= sda_s_r;
                                if (shift_r[6:0] == SLAVE_ADDR) begin
                                    // Only reads convert: track from R/W rise
                                    if (sda_s_r) begin
                                        track_o <= 1'b1;
                                    end
                                end
                            end
                        end else if (scl_fall && bit_r == 4'h8) begin
                            if (addr_hit) begin
                                sda_low_r <= 1'b1;
                                state_r <= ST_AACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        // End of ninth clock: release the acknowledge
                        if (scl_fall) begin
                            sda_low_r <= 1'b0;
                            bit_r <= 4'h0;
                            lo_byte_r <= 1'b0;
                            rise_cnt_r <= 4'h0;
                            if (!rw_r) begin
                                track_o <= 1'b0;
                                state_r <= ST_WRITE;
                            end else if (!external_clock_o) begin
                                // Hold 1.5 SCL after track, start conversion
                                track_o <= 1'b0;
                                sar_start_r <= 1'b1;
                                sda_low_r <= 1'b1; // Pad MSB zero, set while SCL low
                                // SCL low keeps the master waiting
                                scl_low_r <= 1'b1;
                                state_r <= ST_CONV;
                            end else begin
                                shift_r <= {6'h00, result_o[9:8]};
                                state_r <= ST_READ;
                                sda_low_r <= 1'b1; // First pad bit is zero
                            end
                        end
                    end
                    ST_CONV: begin
                        // Let SCL go only with the result in hand
                        if (result_valid_o) begin
                            scl_low_r <= 1'b0;
                            shift_r <= {6'h00, result_o[9:8]};
                            state_r <= ST_READ;
                        end
                    end
                    ST_WRITE: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s_r};
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_fall && bit_r == 4'h8) begin
                            sda_low_r <= 1'b1;
                            state_r <= ST_WACK;
                            // MSB tells setup from configuration
                            if (shift_r[`TWASS_REG_BIT]) begin
                                reference_select_o <=
                                    shift_r[`TWASS_SU_REFSEL_HI:`TWASS_SU_REFSEL_LO];
                                external_clock_o <= shift_r[`TWASS_SU_CLK_BIT];
                                polarity_select_o <= shift_r[`TWASS_SU_POL_BIT];
                                if (!shift_r[`TWASS_SU_RSTN_BIT]) begin
                                    // Configuration back to defaults, setup kept
                                    scan_select_o <= `TWASS_RST_SCAN;
                                    channel_select_o <= `TWASS_RST_CS;
                                    single_diff_select_o <= `TWASS_RST_SGL;
                                end
                            end else begin
                                scan_select_o <=
                                    shift_r[`TWASS_CF_SCAN_HI:`TWASS_CF_SCAN_LO];
                                // Mux choice: input vs ground or pair
                                channel_select_o <= shift_r[`TWASS_CF_CS_HI:`TWASS_CF_CS_LO];
                                single_diff_select_o <= shift_r[`TWASS_CF_SGL_BIT];
                            end
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            sda_low_r <= 1'b0;
                            bit_r <= 4'h0;
                            state_r <= ST_WRITE;
                        end
                    end
                    ST_READ: begin
                        if (scl_rise) begin
                            bit_r <= bit_r + 4'h1;
                            // External: hold at second rise, then ten SCL steps
                            if (external_clock_o && !lo_byte_r && rise_cnt_r != 4'hF) begin
                                rise_cnt_r <= rise_cnt_r + 4'h1;
                                if (rise_cnt_r == 4'h1) begin
                                    track_o <= 1'b0;
                                    sar_start_r <= 1'b1;
                                    ext_conv_r <= 1'b1;
                                end
                            end
                        end else if (scl_fall) begin
                            // Change SDA only with SCL low
                            if (bit_r == 4'h8) begin
                                sda_low_r <= 1'b0;
                                state_r <= ST_RACK;
                            end else begin
                                sda_low_r <= ~shift_r[7 - bit_r[2:0]];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            // Master acknowledge low means keep reading
                            lo_byte_r <= ~lo_byte_r;
                            shift_r <= lo_byte_r ? {6'h00, result_o[9:8]} : result_o[7:0];
                            state_r <= sda_s_r ? ST_IDLE : ST_RACK;
                            bit_r <= 4'h0;
                        end else if (scl_fall) begin
                            sda_low_r <= ~shift_r[7];
                            state_r <= ST_READ;
                        end
                    end
                    default: begin // Idle, or a stray code, waits for a start
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // twass_core

/* File: verification/twass_core_chk.sv */
// Purpose: Port-level assertions for the two-wire sample sequencer core
// Assumes: Bench SCL period of 8 mclk cycles, CONV_DIV handed on by the bind
// Notes: Sees only ports of twass_core; attached by bind below
`timescale 1ns/1ps

module twass_core_chk #(
    parameter [7:0] CONV_DIV = 8'h04 // Internal conversion clock divider
) (
    input logic mclk_i,
    input logic reset_i,
    input logic scl_in_i,
    input logic scl_out_o,
    input logic scl_oe_o,
    input logic sda_out_o,
    input logic sda_oe_o,
    input logic track_o,
    input logic external_clock_o,
    input logic result_valid_o,
    input logic busy_o
);
    // Ten steps of CONV_DIV mclk each, with slack for the start and end handshakes
    localparam int CONV_LO = 9 * CONV_DIV;
    localparam int CONV_HI = 11 * CONV_DIV + 4;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    // Open drain: the driven level is never high
    property p_low_only; scl_out_o == 1'b0 && sda_out_o == 1'b0; endproperty
    a_low_only: assert property (p_low_only) else $error("bus line driven high");
    // Tracking starts while SCL is high (edge is seen a few cycles late)
    property p_track_rise; $rose(track_o) |-> scl_in_i; endproperty
    a_track_rise: assert property (p_track_rise) else $error("track began off a rise");
    // Internal hold on a falling edge, then the clock is stretched at once
    property p_int_hold; $fell(track_o) && !external_clock_o |-> ##[0:2] (scl_oe_o && !scl_in_i); endproperty
    a_int_hold: assert property (p_int_hold) else $error("internal hold without stretch");
    // External hold happens on an SCL rise
    property p_ext_hold; $fell(track_o) && external_clock_o |-> scl_in_i; endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("external hold off a rise");
    // Stretch ends only right after a fresh result
    property p_stretch_end; $fell(scl_oe_o) |-> $past(result_valid_o); endproperty
    a_stretch_end: assert property (p_stretch_end) else $error("SCL freed before result");
    // Result strobe is a single cycle
    property p_pulse; result_valid_o |=> !result_valid_o; endproperty
    a_pulse: assert property (p_pulse) else $error("result strobe too long");
    // Sampling switch stays in hold during a conversion
    property p_hold_busy; busy_o |-> !track_o; endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("tracking while converting");
    // Internal conversion length in divided clocks
    property p_int_len; $rose(busy_o) && !external_clock_o |-> ##[CONV_LO:CONV_HI] result_valid_o; endproperty
    a_int_len: assert property (p_int_len) else $error("internal conversion length off");
    // External conversion spans ten SCL periods of 8 cycles
    property p_ext_len; $rose(busy_o) && external_clock_o |-> ##[70:90] result_valid_o; endproperty
    a_ext_len: assert property (p_ext_len) else $error("external conversion length off");
    // Device data moves only while SCL is low
    property p_sda_stable; $changed(sda_oe_o) |-> !scl_in_i; endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("SDA moved with SCL high");

    c_ext: cover property ($rose(busy_o) && external_clock_o);
    c_int: cover property ($rose(busy_o) && !external_clock_o);
    c_stretch: cover property ($fell(scl_oe_o));
endmodule // twass_core_chk

bind twass_core twass_core_chk #(.CONV_DIV(CONV_DIV)) i_twass_core_chk (.mclk_i(mclk_i),
    .reset_i(reset_i), .scl_in_i(scl_in_i), .scl_out_o(scl_out_o), .scl_oe_o(scl_oe_o),
    .sda_out_o(sda_out_o), .sda_oe_o(sda_oe_o), .track_o(track_o),
    .external_clock_o(external_clock_o), .result_valid_o(result_valid_o), .busy_o(busy_o));

/* File: verification/twass_master_mdl.sv */
// Purpose: Behavioural two-wire bus master for the sequencer bench
// Assumes: Wire levels resolved by the bench with pull-ups
// Notes: Bit period 8 mclk; honours clock stretching up to a bound
`timescale 1ns/1ps

module twass_master_mdl (
    input wire mclk_i,
    input wire scl_i,
    input wire sda_i,
    output reg scl_oe_o,
    output reg sda_oe_o
);
    // Lines released at time zero, so the bus idles high
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // Half a bit period; bench rate exceeds the top bus rate for margin
    task automatic half();
        repeat (4) @(negedge mclk_i);
    endtask
    // Master alone opens a transfer
    task automatic start();
        sda_oe_o = 1'b1;
        half();
        scl_oe_o = 1'b1;
        half();
    endtask
    // Wait half a bit period first so SDA never moves in the step SCL falls
    task automatic stop();
        half();
        sda_oe_o = 1'b1;
        half();
        scl_oe_o = 1'b0;
        half();
        sda_oe_o = 1'b0;
        half();
    endtask
    // One bit per SCL period, data set while low, sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        int n;
        @(negedge mclk_i);
        sda_oe_o = !b;
        repeat (3) @(negedge mclk_i);
        scl_oe_o = 1'b0;
        #1;
        n = 0;
        // Slave may stretch the low phase; bounded so a stuck line ends
        while (scl_i !== 1'b1 && n < 2000) begin
            @(negedge mclk_i);
            n++;
        end
        repeat (2) @(negedge mclk_i);
        r = sda_i;
        repeat (2) @(negedge mclk_i);
        scl_oe_o = 1'b1;
    endtask
    // Byte out, MSB first, then the slave's answer bit
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, ack);
    endtask
    // Byte in, then our own ack or nack
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(nack, r);
    endtask
endmodule // twass_master_mdl

/* File: verification/twass_core_tb_top.sv */
// Purpose: Self-checking bench for the sequencer core
// Assumes: Default CONV_DIV, comparator modelled from an ideal code
// Notes: Expected results queued by the driver, popped by the monitor
`timescale 1ns/1ps

module twass_core_tb_top;
    localparam logic [6:0] ADDR = 7'h2A; // Matches the design default
    logic mclk_i, reset_i, comp_i, m_scl_oe, m_sda_oe, neg, scl, sda;
    logic scl_out, scl_oe, sda_out, sda_oe, track, sgl, pol, ext, valid, busy;
    logic [9:0] dac, result, v, e, last;
    logic [3:0] chan;
    logic [2:0] refsel;
    logic [1:0] scan;
    logic [7:0] su, cf;
    logic [16:0] seed = 17'h112D7; // Start value 70359
    logic [9:0] exp_q[$]; // Results still awaited
    int bad_count = 0;
    int comparisons = 0;

    // Pull-ups: any party pulling low wins
    assign scl = !(m_scl_oe || scl_oe);
    assign sda = !(m_sda_oe || sda_oe);

    twass_core i_twass_core (.mclk_i(mclk_i), .reset_i(reset_i), .scl_in_i(scl),
        .scl_out_o(scl_out), .scl_oe_o(scl_oe), .sda_in_i(sda), .sda_out_o(sda_out),
        .sda_oe_o(sda_oe), .comp_i(comp_i), .dac_code_o(dac), .track_o(track),
        .channel_select_o(chan), .single_diff_select_o(sgl), .polarity_select_o(pol),
        .external_clock_o(ext), .reference_select_o(refsel), .scan_select_o(scan),
        .result_o(result), .result_valid_o(valid), .busy_o(busy));
    twass_master_mdl i_twass_master_mdl (.mclk_i(mclk_i), .scl_i(scl), .sda_i(sda),
        .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));

    // 100 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // Ideal comparator; a negative input fails every trial
    always @(negedge mclk_i) comp_i <= !neg && (v >= dac);

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Write transfer of two bytes; nak set when no answer is expected
    task automatic wr(input logic [6:0] ad, input logic [7:0] b0, b1, input logic nak);
        logic a0, a1, a2;
        i_twass_master_mdl.start();
        i_twass_master_mdl.wbyte({ad, 1'b0}, a0);
        i_twass_master_mdl.wbyte(b0, a1);
        i_twass_master_mdl.wbyte(b1, a2);
        i_twass_master_mdl.stop();
        check("write acks", {a0, a1, a2}, {3{nak}});
    endtask
    // Read transfer of 27 clocks: address, high byte, low byte
    task automatic rd(input logic [9:0] xb);
        logic a;
        logic [7:0] hi, lo;
        i_twass_master_mdl.start();
        i_twass_master_mdl.wbyte({ADDR, 1'b1}, a);
        i_twass_master_mdl.rbyte(1'b0, hi);
        i_twass_master_mdl.rbyte(1'b1, lo);
        i_twass_master_mdl.stop();
        check("read ack", a, 1'b0);
        check("high byte", hi, {6'h00, xb[9:8]});
        check("low byte", lo, xb[7:0]);
    endtask

    // Monitor: each result strobe takes the oldest expectation
    always @(negedge mclk_i) begin
        if (valid === 1'b1) begin
            if (exp_q.size() == 0) check("stray result", 10'h3FF, 10'h000);
            else check("result", result, exp_q.pop_front());
        end
    end

    // Watchdog well beyond the expected run
    initial begin
        #400000;
        bad_count++;
        $display("ERROR watchdog expected done seen timeout");
        summarize();
    end

    // Main sequence
    initial begin
        reset_i = 1'b1;
        neg = 1'b0;
        v = 10'h000;
        last = 10'h000;
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i) reset_i = 1'b0;
        check("reset state", {chan, sgl, pol, ext, track, scl_oe, sda_oe}, 10'h020);
        repeat (4) @(negedge mclk_i);
        // Modes: single with bipolar asked, unipolar, negative unipolar, bipolar
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(lfsr(lfsr(seed)));
            su = {1'b1, seed[10:8], 1'b0, (i == 0 || i == 3), 1'b1, 1'b0};
            cf = {1'b0, seed[6:5], seed[4:1], (i == 0)};
            wr(ADDR, su, cf, 1'b0);
            check("config", {chan, sgl, scan, refsel}, {cf[4:0], cf[6:5], su[6:4]});
            check("setup", {pol, ext}, {su[2], 1'b0});
            v = seed[16:7];
            neg = (i == 2);
            e = (i == 2) ? 10'h000 : ((i == 3) ? v ^ 10'h200 : v);
            exp_q.push_back(e);
            rd(e);
            last = e;
        end
        neg = 1'b0;
        // Setup with its reset bit low restores the configuration
        wr(ADDR, 8'h80, 8'h80, 1'b0);
        check("config reset", {chan, sgl, scan}, 10'h004);
        // Foreign address is ignored
        wr(7'h2B, 8'h8A, 8'h8A, 1'b1);
        check("ignored", ext, 1'b0);
        // External clock, single-ended: reads return the prior conversion
        wr(ADDR, 8'h8A, 8'h01, 1'b0);
        check("ext mode", {ext, sgl}, 2'h3);
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(lfsr(lfsr(seed)));
            v = seed[16:7];
            exp_q.push_back(v);
            rd(last);
            last = v;
        end
        repeat (20) @(negedge mclk_i);
        check("pending results", exp_q.size(), 10'h000);
        summarize();
    end
endmodule // twass_core_tb_top
